/* File: shared/dalu_dec_pkg.sv */
`default_nettype none
package dalu_dec_pkg;
   // destination selects
   typedef enum logic [2:0] {
      DST_NONE = 3'h0,
      DST_ACC0 = 3'h1,
      DST_ACC1 = 3'h2,
      DST_DR0  = 3'h3,
      DST_DR1  = 3'h4,
      DST_DR2  = 3'h5
   } dst_t;
   // source register selects
   typedef enum logic [2:0] {
      SRC_NONE   = 3'h0,
      SRC_ACC0   = 3'h1,
      SRC_ACC1   = 3'h2,
      SRC_DR0    = 3'h3,
      SRC_DR1    = 3'h4,
      SRC_DR2    = 3'h5,
      SRC_ACC0HI = 3'h6,
      SRC_ACC1HI = 3'h7
   } src_t;
   // non-multiply and multiply operations
   typedef enum logic [4:0] {
      OP_NONE   = 5'h00,
      OP_ADD    = 5'h01,
      OP_SUB    = 5'h02,
      OP_CMP    = 5'h03,
      OP_TFR    = 5'h04,
      OP_OR     = 5'h05,
      OP_AND    = 5'h06,
      OP_XOR    = 5'h07,
      OP_DECREMENT_WORD   = 5'h08,
      OP_INCREMENT_WORD   = 5'h09,
      OP_NEGATE = 5'h0a,
      OP_NOT    = 5'h0b,
      OP_ROUND  = 5'h0c,
      OP_TEST   = 5'h0d,
      OP_ABSV   = 5'h0e,
      OP_CLRACC = 5'h0f,
      OP_ASL    = 5'h10,
      OP_ROL    = 5'h11,
      OP_ASR    = 5'h12,
      OP_ROR    = 5'h13,
      OP_MPY    = 5'h14,
      OP_MAC    = 5'h15,
      OP_MPYRND = 5'h16,
      OP_MACRND = 5'h17
   } op_t;
   // operand classes presented by the fetch stage
   typedef enum logic [2:0] {
      CLS_NONMPY  = 3'h0,
      CLS_MULT    = 3'h1,
      CLS_SHIFT   = 3'h2,
      CLS_SUMULT  = 3'h3,
      CLS_QQOTHER = 3'h4,
      CLS_ADDSUB  = 3'h5
   } cls_t;
   // opcode field positions
   localparam int DST1_BIT   = 0;
   localparam int EXT_BIT    = 2;
   localparam int SELLO_BIT  = 8;
   localparam int GRP_LO     = 4;
   localparam int QQQ_LO     = 4;
   localparam int FFF_LO     = 0;
   localparam int LLL_LO     = 8;
   localparam int CNT_BITS   = 4;
   localparam logic [15:0] RSVD_WORD = 16'he042;
endpackage
`default_nettype wire

/* File: logic/dalu_operand_decoder.sv */
// Contract
// - single destination bit: 0 picks first accumulator, 1 picks second; here bit 0 set falls in an unbuilt table and is flagged illegal, never acc1
// - complementary source is the accumulator not chosen as destination
// - two-bit data source: 00 dr0, 01 dr1, 11 dr2, 10 reserved
// - three-bit dest: 000 acc0, 100 acc1, 001/011/111 data regs, 101 reserved
// - multiply family accepts data registers through three-bit dest
// - shifts use three-bit dest; shift-accumulate acc only; left-data shift data only
// - add/sub/compare dest: 000,001 accs, 100,110,111 data regs, 101 reserved
// - shift source pairs in fixed order; 000 and 110 reserved
// - first shift operand is value, second gives count from 4 low bits
// - signed/unsigned multiply pairs ordered; first signed, second unsigned
// - other pair users take same pairs, order carries no meaning
// - multiply op field selects plain, negated, accumulate and rounded forms
// - extended bit selects carry, borrow, normalize, logic shift, divide set; here every extended-table word is flagged illegal
// - selector resolved together with bits 6-4 and bit 2
// - bits 2 and 0 pick one of four operation tables
// - group 000: even codes take complementary acc, odd codes take data reg
// - single-operand accumulator groups decode as listed
// - data-register groups decode add, or, transfer, sub, and, compare, xor
// - unavailable or conditional-transfer cells never decode as alu ops
// - reserved pattern never decodes as standalone instruction
`default_nettype none
module dalu_operand_decoder
   import dalu_dec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rstn,
   input  wire logic        opValid,
   input  wire logic [15:0] opWord,
   input  wire logic [2:0]  opClass,
   input  wire logic        accOnlyDst,
   input  wire logic        dataOnlyDst,
   output logic             decValid_r,
   output op_t              aluOp_r,
   output dst_t             dstSel_r,
   output src_t             srcA_r,
   output src_t             srcB_r,
   output logic             negProd_r,
   output logic             firstSigned_r,
   output logic             orderFixed_r,
   output logic [3:0]       cntMask_r,
   output logic             extTable_r,
   output logic [1:0]       tableSel_r,
   output logic             illegal_r
);
   op_t          opNxt;
   dst_t         dstNxt;
   src_t         aNxt;
   src_t         bNxt;
   logic         illNxt;
   logic [2:0]   sel;
   logic [2:0]   grp;
   logic [2:0]   fff;
   logic [1:0]   tbl;
   logic         dst1;
   dst_t         accDst;
   src_t         accCompl;
   src_t         grpSrc;

   assign sel  = opWord[SELLO_BIT +: 3];
   assign grp  = opWord[GRP_LO +: 3];
   assign fff  = opWord[FFF_LO +: 3];
   assign dst1 = opWord[DST1_BIT];
   assign tbl  = {opWord[EXT_BIT], opWord[DST1_BIT]};

   // accumulator destination and its complement
   assign accDst   = dst1 ? DST_ACC1 : DST_ACC0;
   assign accCompl = dst1 ? SRC_ACC0 : SRC_ACC1;

   always_comb begin
      case (grp)
         3'h4:    grpSrc = SRC_DR0;
         3'h5:    grpSrc = SRC_DR1;
         3'h7:    grpSrc = SRC_DR2;
         default: grpSrc = SRC_NONE;
      endcase
   end

   always_comb begin
      opNxt  = OP_NONE;
      dstNxt = DST_NONE;
      aNxt   = SRC_NONE;
      bNxt   = SRC_NONE;
      illNxt = 1'b0;
      case (opClass)
         CLS_NONMPY: begin
            // only table 00 is handled; others flagged so they never execute
            if (tbl != 2'h0) begin
               illNxt = 1'b1;
            end else begin
               dstNxt = accDst;
               case (grp)
                  3'h0: begin
                     aNxt = sel[0] ? SRC_DR1 : accCompl;
                     case (sel)
                        3'h0:    opNxt = OP_ADD;
                        3'h2:    opNxt = OP_TFR;
                        3'h4:    opNxt = OP_SUB;
                        3'h6:    opNxt = OP_CMP;
                        3'h1:    opNxt = OP_ADD;
                        3'h5:    opNxt = OP_SUB;
                        default: illNxt = 1'b1;
                     endcase
                  end
                  3'h1: begin
                     case (sel)
                        3'h0:    opNxt = OP_DECREMENT_WORD;
                        3'h2:    opNxt = OP_NEGATE;
                        3'h3:    opNxt = OP_NOT;
                        3'h4:    opNxt = OP_ROUND;
                        3'h6:    opNxt = OP_TEST;
                        default: illNxt = 1'b1;
                     endcase
                  end
                  3'h2: begin
                     if (sel == 3'h2) opNxt = OP_ABSV;
                     else illNxt = 1'b1;
                  end
                  3'h3: begin
                     case (sel)
                        3'h0:    opNxt = OP_INCREMENT_WORD;
                        3'h2:    opNxt = OP_CLRACC;
                        3'h4:    opNxt = OP_ASL;
                        3'h5:    opNxt = OP_ROL;
                        3'h6:    opNxt = OP_ASR;
                        3'h7:    opNxt = OP_ROR;
                        default: illNxt = 1'b1;
                     endcase
                  end
                  3'h4, 3'h5, 3'h7: begin
                     aNxt = grpSrc;
                     case (sel)
                        3'h0:    opNxt = OP_ADD;
                        3'h1:    opNxt = OP_OR;
                        3'h2:    opNxt = OP_TFR;
                        3'h4:    opNxt = OP_SUB;
                        3'h5:    opNxt = OP_AND;
                        3'h6:    opNxt = OP_CMP;
                        3'h7:    opNxt = OP_XOR;
                        default: illNxt = 1'b1;
                     endcase
                  end
                  default: illNxt = 1'b1;
               endcase
               if (illNxt) begin
                  dstNxt = DST_NONE;
                  aNxt   = SRC_NONE;
               end
            end
         end
         CLS_MULT, CLS_SHIFT, CLS_SUMULT, CLS_QQOTHER: begin
            if (opClass == CLS_MULT) begin
               case (opWord[LLL_LO+1 +: 2])
                  2'h0:    opNxt = OP_MPY;
                  2'h1:    opNxt = OP_MAC;
                  2'h2:    opNxt = OP_MPYRND;
                  default: opNxt = OP_MACRND;
               endcase
            end
            case (fff)
               3'h0:    dstNxt = DST_ACC0;
               3'h4:    dstNxt = DST_ACC1;
               3'h1:    dstNxt = DST_DR0;
               3'h3:    dstNxt = DST_DR1;
               3'h7:    dstNxt = DST_DR2;
               default: illNxt = 1'b1;
            endcase
            if (opClass == CLS_SHIFT) begin
               if (accOnlyDst && !(fff == 3'h0 || fff == 3'h4)) illNxt = 1'b1;
               if (dataOnlyDst && (fff == 3'h0 || fff == 3'h4)) illNxt = 1'b1;
            end
            // shift order is the mirror of the multiply order, same pairs
            case (opWord[QQQ_LO +: 3])
               3'h1: begin aNxt = SRC_DR2; bNxt = SRC_ACC1HI; end
               3'h2: begin aNxt = SRC_DR1; bNxt = SRC_DR1;    end
               3'h3: begin aNxt = SRC_DR1; bNxt = SRC_ACC0HI; end
               3'h4: begin aNxt = SRC_DR0; bNxt = SRC_DR1;    end
               3'h5: begin aNxt = SRC_DR0; bNxt = SRC_DR2;    end
               3'h7: begin aNxt = SRC_DR1; bNxt = SRC_DR2;    end
               default: illNxt = 1'b1;
            endcase
            if (opClass == CLS_SHIFT) begin
               aNxt = bNxt;
               bNxt = src_t'(opWord[QQQ_LO +: 3] == 3'h1 ? SRC_DR2 :
                             opWord[QQQ_LO +: 3] == 3'h2 ? SRC_DR1 :
                             opWord[QQQ_LO +: 3] == 3'h3 ? SRC_DR1 :
                             opWord[QQQ_LO +: 3] == 3'h4 ? SRC_DR0 :
                             opWord[QQQ_LO +: 3] == 3'h5 ? SRC_DR0 : SRC_DR1);
               if (opWord[QQQ_LO +: 3] == 3'h2 || opWord[QQQ_LO +: 3] == 3'h4 ||
                   opWord[QQQ_LO +: 3] == 3'h5 || opWord[QQQ_LO +: 3] == 3'h7) begin
                  aNxt = (opWord[QQQ_LO +: 3] == 3'h2 || opWord[QQQ_LO +: 3] == 3'h4)
                         ? SRC_DR1 : SRC_DR2;
               end
            end
            if (illNxt) begin
               opNxt  = OP_NONE;
               dstNxt = DST_NONE;
               aNxt   = SRC_NONE;
               bNxt   = SRC_NONE;
            end
         end
         CLS_ADDSUB: begin
            case (fff)
               3'h0:    dstNxt = DST_ACC0;
               3'h1:    dstNxt = DST_ACC1;
               3'h4:    dstNxt = DST_DR0;
               3'h6:    dstNxt = DST_DR1;
               3'h7:    dstNxt = DST_DR2;
               default: illNxt = 1'b1;
            endcase
         end
         default: illNxt = 1'b1;
      endcase
      if (opWord == RSVD_WORD) begin
         opNxt  = OP_NONE;
         dstNxt = DST_NONE;
         aNxt   = SRC_NONE;
         bNxt   = SRC_NONE;
         illNxt = 1'b1;
      end
   end

   // decode registered one edge after the word is presented
   always_ff @(posedge clk) begin
      if (!rstn) begin
         decValid_r    <= 1'b0;
         aluOp_r       <= OP_NONE;
         dstSel_r      <= DST_NONE;
         srcA_r        <= SRC_NONE;
         srcB_r        <= SRC_NONE;
         negProd_r     <= 1'b0;
         firstSigned_r <= 1'b0;
         orderFixed_r  <= 1'b0;
         cntMask_r     <= 4'h0;
         extTable_r    <= 1'b0;
         tableSel_r    <= 2'h0;
         illegal_r     <= 1'b0;
      end else if (opValid) begin
         decValid_r    <= 1'b1;
         aluOp_r       <= opNxt;
         dstSel_r      <= dstNxt;
         srcA_r        <= aNxt;
         srcB_r        <= bNxt;
         negProd_r     <= (opClass == CLS_MULT) && opWord[LLL_LO] && !illNxt;
         firstSigned_r <= (opClass == CLS_SUMULT) && !illNxt;
         orderFixed_r  <= (opClass == CLS_SHIFT || opClass == CLS_SUMULT) && !illNxt;
         cntMask_r     <= (opClass == CLS_SHIFT && !illNxt) ? {CNT_BITS{1'b1}} : 4'h0;
         extTable_r    <= opWord[EXT_BIT];
         tableSel_r    <= tbl;
         illegal_r     <= illNxt;
      end else begin
         decValid_r    <= 1'b0;
         aluOp_r       <= OP_NONE;
         illegal_r     <= 1'b0;
      end
   end
endmodule
`default_nettype wire

/* File: testbench/dalu_dec_chk.sv */
`default_nettype none
module dalu_dec_chk
   import dalu_dec_pkg::*;
(
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        opValid,
   input wire logic [15:0] opWord,
   input wire logic [2:0]  opClass,
   input wire logic        accOnlyDst,
   input wire logic        dataOnlyDst,
   input wire logic        decValid_r,
   input wire op_t         aluOp_r,
   input wire logic        negProd_r,
   input wire logic        firstSigned_r,
   input wire logic        orderFixed_r,
   input wire logic [3:0]  cntMask_r,
   input wire logic        extTable_r,
   input wire logic        illegal_r
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // reserved pair codes are judged by their own assertion
   wire logic pairOk = opWord[6:4] != 3'h0 && opWord[6:4] != 3'h6;
   wire logic nm     = opValid && opClass == 3'h0;
   // three-bit destination codes that name a register
   wire logic dstOk  = opWord[2:0] inside {3'h0, 3'h4, 3'h1, 3'h3, 3'h7};
   a_reset_noop: assert property (disable iff (1'b0)
      !rstn |=> aluOp_r == OP_NONE && !decValid_r && !illegal_r) else $error("reset not noop");
   a_valid_answer: assert property (opValid |=> decValid_r)
      else $error("no answer after request");
   a_idle_clear: assert property (!opValid |=> !decValid_r && aluOp_r == OP_NONE)
      else $error("outputs not cleared when idle");
   a_rsvd_word: assert property (opValid && opWord == RSVD_WORD |=> illegal_r)
      else $error("reserved word decoded");
   a_pair_rsvd: assert property (opValid && opClass inside {3'h2, 3'h3, 3'h4}
      && !pairOk |=> illegal_r) else $error("reserved pair accepted");
   a_shift_cnt: assert property (opValid && opClass == 3'h2 && pairOk && dstOk
      && !accOnlyDst && !dataOnlyDst
      |=> cntMask_r == 4'hf && orderFixed_r) else $error("shift count mask wrong");
   a_su_signed: assert property (opValid && opClass == 3'h3 && pairOk && dstOk
      |=> firstSigned_r)
      else $error("first operand not signed");
   a_any_order: assert property (opValid && opClass == 3'h4 && pairOk |=> !orderFixed_r)
      else $error("order marked fixed");
   a_mult_neg: assert property (opValid && opClass == 3'h1 && opWord[8] && pairOk && dstOk
      && opWord != RSVD_WORD |=> negProd_r)
      else $error("negate lost");
   a_table_rsvd: assert property (nm && opWord[0] |=> illegal_r && aluOp_r == OP_NONE)
      else $error("unbuilt table decoded");
   a_ext_table: assert property (nm && opWord[2] |=> extTable_r)
      else $error("extended table not flagged");
   a_dst_rsvd: assert property (opValid && opClass inside {3'h1, 3'h5}
      && opWord[2:0] == 3'h5 |=> illegal_r) else $error("reserved dest accepted");
   c_illegal: cover property (opValid ##1 illegal_r);
   c_shift: cover property (opValid && opClass == 3'h2 ##1 cntMask_r == 4'hf);
   c_mult: cover property (opValid && opClass == 3'h1 ##1 negProd_r);
endmodule
bind dalu_operand_decoder dalu_dec_chk chk (.clk, .rstn, .opValid, .opWord, .opClass,
   .accOnlyDst, .dataOnlyDst,
   .decValid_r, .aluOp_r, .negProd_r, .firstSigned_r, .orderFixed_r, .cntMask_r,
   .extTable_r, .illegal_r);
`default_nettype wire

/* File: testbench/fetch_model.sv */
`default_nettype none
module fetch_model (
   input  wire logic        clk,
   output var  logic        opValid,
   output var  logic [15:0] opWord,
   output var  logic [2:0]  opClass,
   output var  logic        accOnlyDst,
   output var  logic        dataOnlyDst
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      opValid = 1'b0;
      opWord = 16'h0000;
      opClass = 3'h0;
      accOnlyDst = 1'b0;
      dataOnlyDst = 1'b0;
   end
   // any word is issued as given, reserved pair codes included
   task automatic send(input logic [15:0] w, input logic [2:0] c, input logic a, d);
      @(posedge clk);
      #1;
      opValid = 1'b1;
      opWord = w;
      opClass = c;
      accOnlyDst = a;
      dataOnlyDst = d;
      @(posedge clk);
      #1;
   endtask
   // a released word is not left looking valid
   task automatic stop;
      @(posedge clk);
      #1;
      opValid = 1'b0;
      opWord = ~opWord;
   endtask
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
`default_nettype none
module testbench;
   import dalu_dec_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rstn, opValid, accOnlyDst, dataOnlyDst, decValid_r, negProd_r;
   logic        firstSigned_r, orderFixed_r, extTable_r, illegal_r;
   logic [15:0] opWord;
   logic [2:0]  opClass;
   logic [3:0]  cntMask_r;
   logic [1:0]  tableSel_r;
   op_t         aluOp_r;
   dst_t        dstSel_r;
   src_t        srcA_r, srcB_r;
   int          error_cnt = 0;
   int          total_checks = 0;
   src_t pa [8] = '{SRC_NONE, SRC_ACC1HI, SRC_DR1, SRC_ACC0HI, SRC_DR1, SRC_DR2, SRC_NONE, SRC_DR2};
   src_t pb [8] = '{SRC_NONE, SRC_DR2, SRC_DR1, SRC_DR1, SRC_DR0, SRC_DR0, SRC_NONE, SRC_DR1};
   logic [10:0] accTbl [17] = '{{3'h0, 3'h0, OP_ADD}, {3'h0, 3'h2, OP_TFR}, {3'h0, 3'h4, OP_SUB},
      {3'h0, 3'h6, OP_CMP}, {3'h0, 3'h1, OP_ADD}, {3'h0, 3'h5, OP_SUB}, {3'h1, 3'h0, OP_DECREMENT_WORD},
      {3'h1, 3'h2, OP_NEGATE}, {3'h1, 3'h3, OP_NOT}, {3'h1, 3'h4, OP_ROUND}, {3'h1, 3'h6, OP_TEST},
      {3'h2, 3'h2, OP_ABSV}, {3'h3, 3'h0, OP_INCREMENT_WORD}, {3'h3, 3'h2, OP_CLRACC}, {3'h3, 3'h4, OP_ASL},
      {3'h3, 3'h5, OP_ROL}, {3'h3, 3'h6, OP_ASR}};
   op_t  ops8 [8] = '{OP_ADD, OP_OR, OP_TFR, OP_NONE, OP_SUB, OP_AND, OP_CMP, OP_XOR};
   dst_t d8 [8] = '{DST_ACC0, DST_DR0, DST_NONE, DST_DR1, DST_ACC1, DST_NONE, DST_NONE, DST_DR2};
   fetch_model fm (.clk, .opValid, .opWord, .opClass, .accOnlyDst, .dataOnlyDst);
   dalu_operand_decoder dut (.clk, .rstn, .opValid, .opWord, .opClass, .accOnlyDst,
      .dataOnlyDst, .decValid_r, .aluOp_r, .dstSel_r, .srcA_r, .srcB_r, .negProd_r,
      .firstSigned_r, .orderFixed_r, .cntMask_r, .extTable_r, .tableSel_r, .illegal_r);
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   function automatic logic [15:0] mk(input logic [2:0] k, g, input logic e, f);
      return {5'h00, k, 1'b0, g, 1'b0, e, 1'b0, f};
   endfunction
   task automatic chk(input logic [15:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkIll;
      chk(illegal_r, 1'b1);
      chk(aluOp_r, OP_NONE);
   endtask
   task automatic final_report;
      $display("checks=%0d mismatches=%0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic t_reset;
      rstn = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      rstn = 1'b1;
      chk(decValid_r, 1'b0);
      chk(aluOp_r, OP_NONE);
      chk(dstSel_r, DST_NONE);
      $display("test reset done");
   endtask
   task automatic t_acc;
      logic [5:0] na [6] = '{6'o03, 6'o07, 6'o11, 6'o20, 6'o31, 6'o60};
      foreach (accTbl[i]) begin
         fm.send(mk(accTbl[i][7:5], accTbl[i][10:8], 1'b0, 1'b0), 3'h0, 1'b0, 1'b0);
         chk(aluOp_r, accTbl[i][4:0]);
         chk(dstSel_r, DST_ACC0);
         if (accTbl[i][10:8] == 3'h0)
            chk(srcA_r, accTbl[i][5] ? SRC_DR1 : SRC_ACC1);
      end
      foreach (na[i]) begin
         fm.send(mk(na[i][2:0], na[i][5:3], 1'b0, 1'b0), 3'h0, 1'b0, 1'b0);
         chkIll();
      end
      for (int g = 4; g < 8; g++) begin
         for (int k = 0; k < 8; k++) begin
            fm.send(mk(3'(k), 3'(g), 1'b0, 1'b0), 3'h0, 1'b0, 1'b0);
            if (g == 6 || k == 3)
               chkIll();
            else begin
               chk(aluOp_r, ops8[k]);
               chk(srcA_r, g == 4 ? SRC_DR0 : (g == 5 ? SRC_DR1 : SRC_DR2));
            end
         end
      end
      $display("test nonmultiply done");
   endtask
   task automatic t_mult;
      for (int k = 0; k < 16; k++) begin
         // multiplies read their operands through a valid pair code
         fm.send({5'h00, 3'(k), 1'b0, 3'h1, 1'b0, 3'(k + 3 * (k >> 3))}, 3'h1, 1'b0, 1'b0);
         if (d8[(k + 3 * (k >> 3)) % 8] == DST_NONE)
            chkIll();
         else begin
            chk(aluOp_r, OP_MPY + k[2:1]);
            chk(negProd_r, k[0]);
            chk(dstSel_r, d8[(k + 3 * (k >> 3)) % 8]);
         end
      end
      $display("test multiply done");
   endtask
   task automatic t_pairs;
      for (int c = 2; c < 5; c++) begin
         for (int q = 0; q < 8; q++) begin
            fm.send({9'h000, 3'(q), 4'h0}, 3'(c), 1'b0, 1'b0);
            if (q == 0 || q == 6)
               chkIll();
            else if (c == 2) begin
               chk({srcA_r, srcB_r, cntMask_r}, {pa[q], pb[q], 4'hf});
            end else if (c == 3) begin
               chk({srcA_r, srcB_r, firstSigned_r}, {pb[q], pa[q], 1'b1});
            end else begin
               chk({srcA_r, srcB_r} == {pb[q], pa[q]} || {srcA_r, srcB_r} == {pa[q], pb[q]}, 1);
               chk(orderFixed_r, 1'b0);
            end
         end
      end
      fm.send(16'h0031, 3'h2, 1'b1, 1'b0);
      chkIll();
      fm.send(16'h0030, 3'h2, 1'b0, 1'b1);
      chkIll();
      fm.send(16'h0031, 3'h2, 1'b0, 1'b1);
      chk(dstSel_r, DST_DR0);
      $display("test pairs done");
   endtask
   task automatic t_misc;
      dst_t e [8] = '{DST_ACC0, DST_ACC1, DST_NONE, DST_NONE, DST_DR0, DST_NONE, DST_DR1, DST_DR2};
      foreach (e[i]) begin
         fm.send({13'h0000, 3'(i)}, 3'h5, 1'b0, 1'b0);
         if (i == 5)
            chkIll();
         else if (e[i] != DST_NONE)
            chk(dstSel_r, e[i]);
      end
      fm.send(RSVD_WORD, 3'h0, 1'b0, 1'b0);
      chkIll();
      for (int t = 1; t < 4; t++) begin
         fm.send(mk(3'h0, 3'h4, t[1], t[0]), 3'h0, 1'b0, 1'b0);
         chk({tableSel_r, extTable_r, illegal_r}, {2'(t), t[1], 1'b1});
      end
      fm.stop();
      @(posedge clk);
      #1;
      chk({decValid_r, illegal_r}, 2'b00);
      $display("test misc done");
   endtask
   initial begin
      t_reset();
      t_acc();
      t_mult();
      t_pairs();
      t_misc();
      fm.send(mk(3'h0, 3'h4, 1'b0, 1'b0), 3'h0, 1'b0, 1'b0);
      t_reset();
      final_report();
   end
   initial begin
      #(100 * 3000);
      error_cnt++;
      final_report();
   end
endmodule
`default_nettype wire
